// file: css_map.vh
// Constants for the command source selector
`ifndef CSS_MAP_VH
`define CSS_MAP_VH

`define CSS_ADDR_W 8
`define CSS_DATA_W 32
`define CSS_ADDR_CTRL 8'h00
`define CSS_ADDR_PERM 8'h04
`define CSS_ADDR_STATUS 8'h08
`define CSS_ADDR_EVENT 8'h0c
`define CSS_ADDR_REJCNT 8'h10
`define CSS_ADDR_TERM0 8'h20
`define CSS_ADDR_TERM_LAST 8'h38

`define CSS_TERM_COUNT 7
`define CSS_TERM_IDX_W 3
`define CSS_FUNC_W 8
`define CSS_FUNC_SWITCH 8'h43
`define CSS_FUNC_RESET 8'h00

`define CSS_START_COMM 1'b0
`define CSS_START_TERM 1'b1
`define CSS_SPEED_COMM 2'h0
`define CSS_SPEED_TERM 2'h1
`define CSS_SPEED_BOTH 2'h2
`define CSS_CTRL_START_BIT 0
`define CSS_CTRL_SPEED_LSB 1
`define CSS_CTRL_SPEED_MSB 2
`define CSS_START_RESET 1'b1
`define CSS_SPEED_RESET 2'h1

`define CSS_PERM_W 2
`define CSS_PERM_STOP_ONLY 2'h0
`define CSS_PERM_LOCKED 2'h1
`define CSS_PERM_RUN_OK 2'h2
`define CSS_PERM_RESET 2'h0

`define CSS_EV_REJECT_BIT 0
`define CSS_EV_APPLY_BIT 1
`define CSS_CNT_W 8
`define CSS_CNT_MAX 8'hff

`endif

// file: css_term_map.v
// Input terminal function settings and switchover decode
`default_nettype none
`include "css_map.vh"

module css_term_map (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [`CSS_TERM_IDX_W-1:0] wr_idx,
  input wire [`CSS_FUNC_W-1:0] wr_data,
  input wire [`CSS_TERM_IDX_W-1:0] rd_idx,
  output reg [`CSS_FUNC_W-1:0] rd_data,
  input wire [`CSS_TERM_COUNT-1:0] term_in,
  output wire switch_assigned,
  output wire switch_level
);

  reg [`CSS_FUNC_W-1:0] func_reg [0:`CSS_TERM_COUNT-1];
  wire [`CSS_TERM_COUNT-1:0] is_switch;
  wire [`CSS_TERM_COUNT-1:0] switch_on;

  genvar i;
  generate
    for (i = 0; i < `CSS_TERM_COUNT; i = i + 1) begin : g_term
      always @(posedge clk) begin
        if (rst) begin
          func_reg[i] <= `CSS_FUNC_RESET;
        end else if (wr_en && wr_idx == i) begin
          func_reg[i] <= wr_data;
        end
      end
      assign is_switch[i] = (func_reg[i] == `CSS_FUNC_SWITCH);
      assign switch_on[i] = is_switch[i] & term_in[i];
    end
  endgenerate

  // Several terminals may carry the function; any one on counts as on
  assign switch_assigned = |is_switch;
  assign switch_level = |switch_on;

  always @(posedge clk) begin
    if (rst) begin
      rd_data <= `CSS_FUNC_RESET;
    end else if (rd_idx < `CSS_TERM_COUNT) begin
      rd_data <= func_reg[rd_idx];
    end else begin
      rd_data <= `CSS_FUNC_RESET;
    end
  end

endmodule // css_term_map
`default_nettype wire

// file: css_selector.v
// Command source selector with APB register access
//
// Design decisions made here: the APB register port and the address map.
`default_nettype none
`include "css_map.vh"

module css_selector (
  input wire MCLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`CSS_ADDR_W-1:0] PADDR,
  input wire [`CSS_DATA_W-1:0] PWDATA,
  output wire [`CSS_DATA_W-1:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [`CSS_TERM_COUNT-1:0] TERM_IN,
  input wire NET_MODE,
  input wire DRIVE_STOPPED,
  input wire COMM_RESET_REQ,
  output wire COMM_RESET_OUT,
  output wire START_FROM_TERM,
  output wire START_FROM_COMM,
  output wire SPEED_FROM_TERM,
  output wire SPEED_FROM_COMM
);

  // Software settings
  reg start_source_setting_reg;
  reg [1:0] speed_source_setting_reg;
  reg [`CSS_PERM_W-1:0] write_permission_setting_reg;

  // Selection in force
  reg act_start_comm_reg;
  reg act_speed_term_reg;
  reg act_speed_comm_reg;

  reg comm_reset_reg;
  reg ev_reject_reg;
  reg ev_apply_reg;
  reg [`CSS_CNT_W-1:0] rej_cnt_reg;

  reg wait_done_reg;
  reg [`CSS_DATA_W-1:0] prdata_reg;
  reg [`CSS_DATA_W-1:0] rd_mux;

  wire source_switch_assigned;
  wire source_switch_input;
  wire [`CSS_FUNC_W-1:0] term_rd_data;

  // APB phase decode
  wire access = PSEL & PENABLE;
  wire done = access & wait_done_reg;
  wire wr_done = done & PWRITE;

  wire [`CSS_ADDR_W-1:0] term_off = PADDR - `CSS_ADDR_TERM0;
  wire [`CSS_TERM_IDX_W-1:0] term_idx = term_off[4:2];
  wire aligned = (PADDR[1:0] == 2'h0);
  wire hit_ctrl = (PADDR == `CSS_ADDR_CTRL);
  wire hit_perm = (PADDR == `CSS_ADDR_PERM);
  wire hit_status = (PADDR == `CSS_ADDR_STATUS);
  wire hit_event = (PADDR == `CSS_ADDR_EVENT);
  wire hit_rejcnt = (PADDR == `CSS_ADDR_REJCNT);
  wire hit_term = aligned && (PADDR >= `CSS_ADDR_TERM0) && (PADDR <= `CSS_ADDR_TERM_LAST);
  wire hit_any = hit_ctrl | hit_perm | hit_status | hit_event | hit_rejcnt | hit_term;

  // Settings may be rewritten while running only under permission 2
  wire setting_write_ok =
    (write_permission_setting_reg == `CSS_PERM_RUN_OK) ||
    ((write_permission_setting_reg == `CSS_PERM_STOP_ONLY) && DRIVE_STOPPED);

  wire perm_value_ok = (PWDATA[`CSS_PERM_W-1:0] != 2'h3);

  wire write_refused =
    PWRITE && (((hit_ctrl || hit_term) && !setting_write_ok) ||
               (hit_perm && !perm_value_ok) ||
               hit_status);

  wire slv_err = !hit_any || write_refused;
  wire wr_ok = wr_done && !slv_err;

  assign PREADY = done;
  assign PSLVERR = done & slv_err;
  assign PRDATA = prdata_reg;

  css_term_map u_term_map (
    .clk(MCLK),
    .rst(RST),
    .wr_en(wr_ok && hit_term),
    .wr_idx(term_idx),
    .wr_data(PWDATA[`CSS_FUNC_W-1:0]),
    .rd_idx(term_idx),
    .rd_data(term_rd_data),
    .term_in(TERM_IN),
    .switch_assigned(source_switch_assigned),
    .switch_level(source_switch_input)
  );

  // Switchover assigned and off
  wire switch_off = source_switch_assigned & ~source_switch_input;

  // Selection the current inputs and settings call for
  reg tgt_start_comm;
  reg tgt_speed_term;
  reg tgt_speed_comm;

  always @* begin
    tgt_start_comm = 1'b0;
    tgt_speed_term = 1'b1;
    tgt_speed_comm = 1'b0;
    if (NET_MODE && !switch_off) begin
      tgt_start_comm = (start_source_setting_reg == `CSS_START_COMM);
      case (speed_source_setting_reg)
        `CSS_SPEED_COMM: begin
          tgt_speed_term = 1'b0;
          tgt_speed_comm = 1'b1;
        end
        `CSS_SPEED_BOTH: begin
          tgt_speed_term = 1'b1;
          tgt_speed_comm = 1'b1;
        end
        default: begin
          tgt_speed_term = 1'b1;
          tgt_speed_comm = 1'b0;
        end
      endcase
    end
  end

  wire tgt_differs = (tgt_start_comm != act_start_comm_reg) ||
                     (tgt_speed_term != act_speed_term_reg) ||
                     (tgt_speed_comm != act_speed_comm_reg);

  // Running drive keeps the old selection until it stops
  always @(posedge MCLK) begin
    if (RST) begin
      act_start_comm_reg <= 1'b0;
      act_speed_term_reg <= 1'b1;
      act_speed_comm_reg <= 1'b0;
    end else if (DRIVE_STOPPED) begin
      act_start_comm_reg <= tgt_start_comm;
      act_speed_term_reg <= tgt_speed_term;
      act_speed_comm_reg <= tgt_speed_comm;
    end
  end

  assign START_FROM_COMM = act_start_comm_reg;
  assign START_FROM_TERM = ~act_start_comm_reg;
  assign SPEED_FROM_TERM = act_speed_term_reg;
  assign SPEED_FROM_COMM = act_speed_comm_reg;

  // Communication reset passes one cycle later unless blocked
  wire reset_blocked = COMM_RESET_REQ & switch_off;

  always @(posedge MCLK) begin
    if (RST) begin
      comm_reset_reg <= 1'b0;
    end else begin
      comm_reset_reg <= COMM_RESET_REQ & ~switch_off;
    end
  end

  assign COMM_RESET_OUT = comm_reset_reg;

  always @(posedge MCLK) begin
    if (RST) begin
      rej_cnt_reg <= {`CSS_CNT_W{1'b0}};
    end else if (reset_blocked && rej_cnt_reg != `CSS_CNT_MAX) begin
      rej_cnt_reg <= rej_cnt_reg + 8'h01;
    end else if (wr_ok && hit_rejcnt) begin
      rej_cnt_reg <= {`CSS_CNT_W{1'b0}};
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  wire apply_event = DRIVE_STOPPED & tgt_differs;
  wire clr_reject = wr_ok && hit_event && PWDATA[`CSS_EV_REJECT_BIT];
  wire clr_apply = wr_ok && hit_event && PWDATA[`CSS_EV_APPLY_BIT];

  always @(posedge MCLK) begin
    if (RST) begin
      ev_reject_reg <= 1'b0;
      ev_apply_reg <= 1'b0;
    end else begin
      if (reset_blocked) begin
        ev_reject_reg <= 1'b1;
      end else if (clr_reject) begin
        ev_reject_reg <= 1'b0;
      end
      if (apply_event) begin
        ev_apply_reg <= 1'b1;
      end else if (clr_apply) begin
        ev_apply_reg <= 1'b0;
      end
    end
  end

  // Setting registers
  always @(posedge MCLK) begin
    if (RST) begin
      start_source_setting_reg <= `CSS_START_RESET;
      speed_source_setting_reg <= `CSS_SPEED_RESET;
    end else if (wr_ok && hit_ctrl) begin
      start_source_setting_reg <= PWDATA[`CSS_CTRL_START_BIT];
      speed_source_setting_reg <= PWDATA[`CSS_CTRL_SPEED_MSB:`CSS_CTRL_SPEED_LSB];
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      write_permission_setting_reg <= `CSS_PERM_RESET;
    end else if (wr_ok && hit_perm) begin
      write_permission_setting_reg <= PWDATA[`CSS_PERM_W-1:0];
    end
  end

  // Read data mux
  always @* begin
    rd_mux = {`CSS_DATA_W{1'b0}};
    if (hit_ctrl) begin
      rd_mux[`CSS_CTRL_START_BIT] = start_source_setting_reg;
      rd_mux[`CSS_CTRL_SPEED_MSB:`CSS_CTRL_SPEED_LSB] = speed_source_setting_reg;
    end else if (hit_perm) begin
      rd_mux[`CSS_PERM_W-1:0] = write_permission_setting_reg;
    end else if (hit_status) begin
      rd_mux[7:0] = {NET_MODE, DRIVE_STOPPED, tgt_differs, source_switch_input,
                     source_switch_assigned, act_speed_comm_reg, act_speed_term_reg,
                     act_start_comm_reg};
    end else if (hit_event) begin
      rd_mux[`CSS_EV_REJECT_BIT] = ev_reject_reg;
      rd_mux[`CSS_EV_APPLY_BIT] = ev_apply_reg;
    end else if (hit_rejcnt) begin
      rd_mux[`CSS_CNT_W-1:0] = rej_cnt_reg;
    end else if (hit_term) begin
      rd_mux[`CSS_FUNC_W-1:0] = term_rd_data;
    end
  end

  // One wait state; read data captured on the first access edge
  always @(posedge MCLK) begin
    if (RST) begin
      wait_done_reg <= 1'b0;
      prdata_reg <= {`CSS_DATA_W{1'b0}};
    end else if (done) begin
      wait_done_reg <= 1'b0;
    end else if (access) begin
      wait_done_reg <= 1'b1;
      if (!PWRITE) begin
        prdata_reg <= rd_mux;
      end
    end
  end

endmodule // css_selector
`default_nettype wire

// file: css_selector_monitor.sv
// Concurrent checks on the command source selector ports
`default_nettype none
`include "css_map.vh"
module css_selector_monitor (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic NET_MODE,
  input wire logic DRIVE_STOPPED,
  input wire logic COMM_RESET_REQ,
  input wire logic COMM_RESET_OUT,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic START_FROM_TERM,
  input wire logic START_FROM_COMM,
  input wire logic SPEED_FROM_TERM,
  input wire logic SPEED_FROM_COMM
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic [3:0] sel = {START_FROM_TERM, START_FROM_COMM, SPEED_FROM_TERM, SPEED_FROM_COMM};
  property p_hold; !DRIVE_STOPPED |=> $stable(sel); endproperty
  a_hold: assert property (p_hold) else $error("selection moved while running");
  property p_load; !$stable(sel) |-> $past(DRIVE_STOPPED); endproperty
  a_load: assert property (p_load) else $error("selection loaded while running");
  property p_local; !NET_MODE && DRIVE_STOPPED |=> sel == 4'b1010; endproperty
  a_local: assert property (p_local) else $error("local mode not terminal");
  property p_compl; START_FROM_TERM != START_FROM_COMM; endproperty
  a_compl: assert property (p_compl) else $error("start source not unique");
  property p_speed; SPEED_FROM_TERM || SPEED_FROM_COMM; endproperty
  a_speed: assert property (p_speed) else $error("no speed source");
  property p_rst_src; COMM_RESET_OUT |-> $past(COMM_RESET_REQ); endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset out without request");
  property p_rst_one; !COMM_RESET_REQ |=> !COMM_RESET_OUT; endproperty
  a_rst_one: assert property (p_rst_one) else $error("reset out too long");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule // css_selector_monitor
bind css_selector css_selector_monitor u_mon (.MCLK(MCLK), .RST(RST), .NET_MODE(NET_MODE),
  .DRIVE_STOPPED(DRIVE_STOPPED), .COMM_RESET_REQ(COMM_RESET_REQ),
  .COMM_RESET_OUT(COMM_RESET_OUT), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .START_FROM_TERM(START_FROM_TERM), .START_FROM_COMM(START_FROM_COMM),
  .SPEED_FROM_TERM(SPEED_FROM_TERM), .SPEED_FROM_COMM(SPEED_FROM_COMM));
`default_nettype wire

// file: css_far_end.sv
// Terminal inputs and communication controller model
`default_nettype none
module css_far_end (
  input wire logic clk,
  input wire logic [6:0] lvl,
  input wire logic fire,
  output logic [6:0] TERM_IN,
  output logic COMM_RESET_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  initial TERM_IN = 7'h00;
  initial COMM_RESET_REQ = 1'b0;
  // Request follows fire one cycle later and stays high for as many cycles as fire
  always @(posedge clk) begin
    TERM_IN <= lvl;
    COMM_RESET_REQ <= fire;
  end
endmodule // css_far_end
`default_nettype wire

// file: tb_command_source_selector.sv
// Self-checking bench for the command source selector
`default_nettype none
`include "css_map.vh"
module tb_command_source_selector;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 0, RST = 1, psel = 0, penable = 0, pwrite = 0, net = 0, stp = 1, fire = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [6:0] lvl = 7'h00, TERM_IN;
  logic e, req;
  wire logic [31:0] PRDATA;
  wire logic PREADY, PSLVERR, rout, sft, sfc, spt, spc;
  int fails = 0, compares = 0, pulses = 0, want = 0, rej = 0, i, c;
  logic [15:0] r = 16'h3252;
  always #10 MCLK = ~MCLK;
  always @(posedge MCLK) if (rout === 1'b1) pulses++;
  css_far_end fe (.clk(MCLK), .lvl(lvl), .fire(fire), .TERM_IN(TERM_IN), .COMM_RESET_REQ(req));
  css_selector uut (.MCLK(MCLK), .RST(RST), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TERM_IN(TERM_IN), .NET_MODE(net), .DRIVE_STOPPED(stp), .COMM_RESET_REQ(req),
    .COMM_RESET_OUT(rout), .START_FROM_TERM(sft), .START_FROM_COMM(sfc),
    .SPEED_FROM_TERM(spt), .SPEED_FROM_COMM(spc));
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge MCLK);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge MCLK);
    penable <= 1;
    // Right after the edge the design still shows its pre-edge values
    for (k = 0; k < 20; k++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    if (k == 20) begin fails++; give_verdict; end
    q = PRDATA;
    e = PSLVERR;
    psel <= 0; penable <= 0;
  endtask
  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected selection: start term/comm, speed term/comm
  function logic [3:0] sel(input int n, input int s, input int cv);
    int sp;
    sp = (cv >> 1) & 3;
    if (n == 0 || s == 0) return 4'b1010;
    return {(cv & 1) ? 2'b10 : 2'b01, sp == 0 ? 2'b01 : sp == 2 ? 2'b11 : 2'b10};
  endfunction
  task look(input logic [3:0] x);
    repeat (3) @(posedge MCLK);
    chk("select", {sft, sfc, spt, spc}, x);
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 0;
    chk("reset select", {sft, sfc, spt, spc}, 4'b1010);
    apb(1, `CSS_ADDR_TERM0, 32'h43);
    apb(1, `CSS_ADDR_CTRL, 32'h0);
    net <= 1; lvl <= 7'h01;
    look(4'b0101);
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      c = r[2:0];
      apb(1, `CSS_ADDR_CTRL, c);
      apb(0, `CSS_ADDR_CTRL, 0);
      chk("ctrl", q, c);
      lvl <= {6'h0, r[3]}; fire <= 1;
      want += r[3];
      rej += !r[3];
      @(posedge MCLK) fire <= 0;
      look(sel(1, r[3], c));
      chk("resets", pulses, want);
    end
    apb(0, `CSS_ADDR_REJCNT, 0);
    chk("rejcnt", q, rej);
    apb(1, `CSS_ADDR_PERM, 32'h2);
    apb(1, `CSS_ADDR_CTRL, 32'h0);
    lvl <= 7'h01;
    look(4'b0101);
    stp <= 0;
    apb(1, `CSS_ADDR_CTRL, 32'h5);
    chk("run write", e, 1'b0);
    lvl <= 7'h00;
    look(4'b0101);
    lvl <= 7'h01;
    look(4'b0101);
    stp <= 1;
    look(4'b1011);
    apb(0, 8'h40, 0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0);
    net <= 0;
    look(4'b1010);
    give_verdict;
  end
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
endmodule // tb_command_source_selector
`default_nettype wire
